// >>> verilog/scp_parser.sv
`timescale 1ns/1ps
module scp_parser #(
  parameter int DEPTH = scp_pkg::MSG_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              port_serial,
  input  wire logic              rx_valid,
  input  scp_pkg::scp_byte_t     rx,
  output logic                   rx_ready,
  input  wire logic              le_wr,
  input  scp_pkg::scp_le_t       le_val,
  input  wire logic              nv_le_valid,
  input  scp_pkg::scp_le_t       nv_le,
  output scp_pkg::scp_le_t       le_mode,
  output logic                   cmd_valid,
  output scp_pkg::scp_cmd_t      cmd,
  output logic                   esr_opc_set,
  output logic                   esr_cme_set,
  output logic                   err_push,
  output logic                   tx_valid,
  output scp_pkg::scp_byte_t     tx,
  input  wire logic              tx_ready,
  input  wire logic              srq_req,
  output logic                   srq_out
);
  scp_pkg::scp_state_t st_q;
  scp_pkg::scp_le_t    le_q;
  logic                loaded_q;
  logic [AW:0]         wr_ptr_q;
  logic [AW:0]         len_q;
  logic [AW:0]         rd_ptr_q;
  logic                ovf_q;
  logic                cr_pend_q;
  logic                at_end_q;
  logic [7:0]          mem_rdata;
  logic [63:0]         kw_q;
  logic [3:0]          kw_len_q;
  logic                hdr_q;
  logic                qry_q;
  logic                route_q;
  logic                quote_q;
  logic                has_par_q;
  logic                bad_q;
  scp_pkg::scp_code_t  code_q;
  logic [7:0]          par_q;
  logic                cmd_valid_q;
  scp_pkg::scp_cmd_t   cmd_q;
  logic                opc_set_q;
  logic                err_q;
  logic                tx_valid_q;
  scp_pkg::scp_byte_t  tx_q;

  logic                acc;
  logic                msg_end;
  logic                store;
  logic                wr_en;
  logic [7:0]          c;
  logic [7:0]          cu;
  logic                digit;
  logic                resolve;
  logic                fin;
  logic                app;
  logic                to_par;
  logic                set_qry;
  logic                qt;
  logic                dig;
  scp_pkg::scp_code_t  k;
  scp_pkg::scp_code_t  code_n;
  logic                route_n;
  logic                bad_n;
  logic                qry_n;
  logic                empty_cmd;
  logic                fin_bad;
  logic                fin_ok;
  logic                rpl_go;
  logic                tx_last;
  scp_pkg::scp_byte_t  tx_next;

  assign rx_ready    = (st_q == scp_pkg::ST_FILL);
  assign acc         = rx_valid && rx_ready;
  assign le_mode     = le_q;
  assign cmd_valid   = cmd_valid_q;
  assign cmd         = cmd_q;
  assign esr_opc_set = opc_set_q;
  assign esr_cme_set = err_q;
  assign err_push    = err_q;
  assign tx_valid    = tx_valid_q;
  assign tx          = tx_q;
  // Serial link has no service request line at all
  assign srq_out     = srq_req && !port_serial;

  // Stored choice is taken once, on the first edge after reset release
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      le_q     <= scp_pkg::LE_RESET;
      loaded_q <= 1'b0;
    end
    else if (!loaded_q)
    begin
      loaded_q <= 1'b1;
      if (nv_le_valid)
      begin
        le_q <= nv_le;
      end
    end
    else if (le_wr)
    begin
      le_q <= le_val;
    end
  end

  always_comb
  begin
    msg_end = 1'b0;
    store   = 1'b0;
    if (acc)
    begin
      if (!port_serial)
      begin
        msg_end = (rx.data == scp_pkg::CH_LF) || rx.eoi;
        store   = (rx.data != scp_pkg::CH_LF);
      end
      else
      begin
        case (le_q)
          scp_pkg::LE_CR:
          begin
            msg_end = (rx.data == scp_pkg::CH_CR);
            store   = !msg_end;
          end
          scp_pkg::LE_CRLF:
          begin
            msg_end = cr_pend_q && (rx.data == scp_pkg::CH_LF);
            store   = (rx.data != scp_pkg::CH_CR) && !msg_end;
          end
          default:
          begin
            msg_end = (rx.data == scp_pkg::CH_LF);
            store   = !msg_end;
          end
        endcase
      end
    end
  end

  assign wr_en = store && (wr_ptr_q != (AW + 1)'(DEPTH));

  scp_msg_mem #(
    .W     (8),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .clk     (mclk),
    .we      (wr_en),
    .waddr   (wr_ptr_q[AW-1:0]),
    .wdata   (rx.data),
    .raddr   (rd_ptr_q[AW-1:0]),
    .rdata_q (mem_rdata)
  );

  // Whole message is held before any of it is parsed
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wr_ptr_q  <= '0;
      len_q     <= '0;
      ovf_q     <= 1'b0;
      cr_pend_q <= 1'b0;
    end
    else if (acc)
    begin
      cr_pend_q <= port_serial && (le_q == scp_pkg::LE_CRLF) && (rx.data == scp_pkg::CH_CR);
      if (store && !wr_en)
      begin
        ovf_q <= 1'b1;
      end
      if (msg_end)
      begin
        len_q    <= wr_ptr_q + (AW + 1)'(wr_en);
        wr_ptr_q <= '0;
      end
      else if (wr_en)
      begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
    end
    else if ((st_q == scp_pkg::ST_RD && ovf_q) || (st_q == scp_pkg::ST_CH && at_end_q))
    begin
      ovf_q <= 1'b0;
    end
  end

  // Past the last stored byte a virtual separator closes the final command
  assign c     = at_end_q ? scp_pkg::CH_SEMI : mem_rdata;
  assign cu    = scp_pkg::upcase(c);
  assign digit = (c >= scp_pkg::CH_ZERO) && (c <= scp_pkg::CH_NINE);

  always_comb
  begin
    resolve = 1'b0;
    fin     = 1'b0;
    app     = 1'b0;
    to_par  = 1'b0;
    set_qry = 1'b0;
    qt      = 1'b0;
    dig     = 1'b0;
    if (st_q == scp_pkg::ST_CH)
    begin
      if (hdr_q)
      begin
        if (c == scp_pkg::CH_COLON)
        begin
          resolve = 1'b1;
        end
        else if (c == scp_pkg::CH_QUERY)
        begin
          resolve = 1'b1;
          set_qry = 1'b1;
        end
        else if (c == scp_pkg::CH_SP)
        begin
          resolve = (kw_len_q != 4'h0);
          to_par  = resolve || qry_q || route_q || (code_q != scp_pkg::CMD_NONE);
        end
        else if (c == scp_pkg::CH_SEMI)
        begin
          resolve = (kw_len_q != 4'h0);
          fin     = 1'b1;
        end
        else if (c != scp_pkg::CH_CR && c != scp_pkg::CH_LF)
        begin
          app = 1'b1;
        end
      end
      else if (c == scp_pkg::CH_QUOTE)
      begin
        qt = 1'b1;
      end
      // An unclosed quote must not leak parse state into the next message
      else if ((!quote_q || at_end_q) && c == scp_pkg::CH_SEMI)
      begin
        fin = 1'b1;
      end
      else if (!quote_q && digit)
      begin
        dig = 1'b1;
      end
    end
  end

  // Walk one level down the tree for each finished keyword
  always_comb
  begin
    k       = scp_pkg::kw_lookup(kw_q, kw_len_q);
    code_n  = code_q;
    route_n = route_q;
    qry_n   = qry_q || set_qry;
    bad_n   = bad_q;
    if (app && (qry_q || kw_len_q == 4'(scp_pkg::KW_CHARS)))
    begin
      bad_n = 1'b1;
    end
    if (app && c == scp_pkg::CH_STAR && kw_len_q != 4'h0)
    begin
      bad_n = 1'b1;
    end
    if ((set_qry || c == scp_pkg::CH_COLON) && hdr_q && qry_q)
    begin
      bad_n = 1'b1;
    end
    if (resolve)
    begin
      case (k)
        scp_pkg::CMD_NONE:
        begin
          bad_n = 1'b1;
        end
        scp_pkg::CMD_ROUTE:
        begin
          bad_n   = bad_n || route_q || (code_q != scp_pkg::CMD_NONE);
          route_n = 1'b1;
        end
        scp_pkg::CMD_OPEN_ALL:
        begin
          bad_n  = bad_n || (code_q != scp_pkg::CMD_OPEN);
          code_n = k;
        end
        scp_pkg::CMD_CLOSE, scp_pkg::CMD_OPEN:
        begin
          bad_n  = bad_n || (code_q != scp_pkg::CMD_NONE);
          code_n = k;
        end
        default:
        begin
          bad_n  = bad_n || route_q || (code_q != scp_pkg::CMD_NONE);
          code_n = k;
        end
      endcase
    end
  end

  assign empty_cmd = (code_n == scp_pkg::CMD_NONE) && !route_n && !bad_n && !qry_n;
  assign fin_bad   = bad_n || (code_n == scp_pkg::CMD_NONE) || (code_n == scp_pkg::CMD_ROUTE) ||
                     !scp_pkg::query_ok(code_n, qry_n);
  assign fin_ok    = fin && !empty_cmd && !fin_bad;
  assign rpl_go    = fin_ok && (code_n == scp_pkg::CMD_OPC) && qry_n;

  always_ff @(posedge mclk)
  begin
    if (sys_rst || (st_q == scp_pkg::ST_CH && fin))
    begin
      kw_q      <= '0;
      kw_len_q  <= '0;
      hdr_q     <= 1'b1;
      qry_q     <= 1'b0;
      route_q   <= 1'b0;
      quote_q   <= 1'b0;
      has_par_q <= 1'b0;
      bad_q     <= 1'b0;
      code_q    <= scp_pkg::CMD_NONE;
      par_q     <= '0;
    end
    else if (st_q == scp_pkg::ST_CH)
    begin
      code_q  <= code_n;
      route_q <= route_n;
      qry_q   <= qry_n;
      bad_q   <= bad_n;
      if (resolve)
      begin
        kw_q     <= '0;
        kw_len_q <= '0;
      end
      else if (app && !bad_n)
      begin
        kw_q     <= {kw_q[55:0], cu};
        kw_len_q <= kw_len_q + 4'h1;
      end
      if (to_par)
      begin
        hdr_q <= 1'b0;
      end
      if (qt)
      begin
        quote_q   <= !quote_q;
        has_par_q <= 1'b1;
      end
      if (dig)
      begin
        par_q     <= 8'(par_q * 8'h0A + (c - scp_pkg::CH_ZERO));
        has_par_q <= 1'b1;
      end
    end
  end

  // Commands leave one at a time in message order, each tagged with the port it came from
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cmd_valid_q <= 1'b0;
      cmd_q       <= '0;
      opc_set_q   <= 1'b0;
      err_q       <= 1'b0;
    end
    else
    begin
      cmd_valid_q <= 1'b0;
      opc_set_q   <= 1'b0;
      err_q       <= (st_q == scp_pkg::ST_RD && ovf_q) ||
                     (st_q == scp_pkg::ST_CH && fin && !empty_cmd && fin_bad);
      if (st_q == scp_pkg::ST_CH && fin_ok && !rpl_go)
      begin
        cmd_valid_q     <= 1'b1;
        cmd_q.code      <= code_n;
        cmd_q.query     <= qry_n;
        cmd_q.has_param <= has_par_q || dig;
        cmd_q.param     <= par_q;
        cmd_q.serial    <= port_serial;
        opc_set_q       <= (code_n == scp_pkg::CMD_OPC);
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_q     <= scp_pkg::ST_FILL;
      rd_ptr_q <= '0;
      at_end_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        scp_pkg::ST_FILL:
        begin
          if (acc && msg_end)
          begin
            st_q     <= scp_pkg::ST_RD;
            rd_ptr_q <= '0;
          end
        end
        scp_pkg::ST_RD:
        begin
          at_end_q <= (rd_ptr_q == len_q);
          st_q     <= ovf_q ? scp_pkg::ST_FILL : scp_pkg::ST_CH;
        end
        scp_pkg::ST_CH:
        begin
          rd_ptr_q <= rd_ptr_q + 1'b1;
          if (rpl_go)
          begin
            st_q <= scp_pkg::ST_RPL;
          end
          else
          begin
            st_q <= at_end_q ? scp_pkg::ST_FILL : scp_pkg::ST_RD;
          end
        end
        scp_pkg::ST_RPL:
        begin
          if (tx_ready && tx_last)
          begin
            st_q <= at_end_q ? scp_pkg::ST_FILL : scp_pkg::ST_RD;
          end
        end
        default:
        begin
          st_q <= scp_pkg::ST_FILL;
        end
      endcase
    end
  end

  // Reply terminator follows the port and the serial line-end mode
  assign tx_last = (tx_q.data == scp_pkg::CH_LF) ||
                   (tx_q.data == scp_pkg::CH_CR && le_q != scp_pkg::LE_CRLF);

  always_comb
  begin
    tx_next.data = scp_pkg::CH_LF;
    tx_next.eoi  = !port_serial;
    if (tx_q.data == scp_pkg::CH_ONE && port_serial && le_q != scp_pkg::LE_LF)
    begin
      tx_next.data = scp_pkg::CH_CR;
      tx_next.eoi  = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      tx_valid_q <= 1'b0;
      tx_q       <= '0;
    end
    else if (st_q == scp_pkg::ST_CH && rpl_go)
    begin
      tx_valid_q <= 1'b1;
      tx_q.data  <= scp_pkg::CH_ONE;
      tx_q.eoi   <= 1'b0;
    end
    else if (tx_valid_q && tx_ready)
    begin
      if (tx_last)
      begin
        tx_valid_q <= 1'b0;
      end
      else
      begin
        tx_q <= tx_next;
      end
    end
  end

  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence s_gpib_lf;
    acc && !port_serial && rx.data == scp_pkg::CH_LF;
  endsequence

  sequence s_opc_query;
    st_q == scp_pkg::ST_CH && fin_ok && code_n == scp_pkg::CMD_OPC && qry_n;
  endsequence

  sequence s_reply_one;
    tx_valid && tx_ready && tx.data == scp_pkg::CH_ONE;
  endsequence

  gpib_lf_end_a: assert property (s_gpib_lf |=> st_q == scp_pkg::ST_RD)
    else $error("GPIB linefeed did not end the message");
  gpib_eoi_end_a: assert property (acc && !port_serial && rx.eoi |=>
    st_q == scp_pkg::ST_RD && !rx_ready)
    else $error("GPIB EOI did not end the message");
  ser_cr_end_a: assert property (acc && port_serial && le_q == scp_pkg::LE_CR &&
    rx.data == scp_pkg::CH_CR |=> st_q == scp_pkg::ST_RD)
    else $error("Serial CR did not end the message");
  ser_crlf_end_a: assert property (acc && port_serial && le_q == scp_pkg::LE_CRLF &&
    rx.data == scp_pkg::CH_CR |=> st_q == scp_pkg::ST_FILL && cr_pend_q)
    else $error("Serial CR ended a CR LF message early");
  le_default_a: assert property ($fell(sys_rst) && !nv_le_valid |=>
    (le_mode == scp_pkg::LE_LF) [*2])
    else $error("Line-end mode did not default to LF");
  reply_lf_end_a: assert property (s_reply_one ##0 port_serial && le_q == scp_pkg::LE_LF |=>
    tx_valid && tx.data == scp_pkg::CH_LF)
    else $error("Reply in LF mode did not end with LF");
  opc_reply_a: assert property (s_opc_query |=>
    tx_valid && tx.data == scp_pkg::CH_ONE && !cmd_valid)
    else $error("Operation-complete query gave no 1");
  opc_flag_a: assert property (st_q == scp_pkg::ST_CH && fin_ok &&
    code_n == scp_pkg::CMD_OPC && !qry_n |=> esr_opc_set && cmd_valid && !tx_valid)
    else $error("Operation-complete flag not set");
  cmd_err_a: assert property (st_q == scp_pkg::ST_CH && fin && !empty_cmd && fin_bad |=>
    esr_cme_set && err_push && !cmd_valid)
    else $error("Bad command did not raise command error");
  short_bad_a: assert property (st_q == scp_pkg::ST_CH && resolve &&
    kw_len_q == 4'h3 && kw_q[23:0] == "CLO" && !fin |=> bad_q)
    else $error("Partial keyword was accepted");
  short_ok_a: assert property (st_q == scp_pkg::ST_CH && c == scp_pkg::CH_COLON &&
    kw_q == 64'("ROUT") && kw_len_q == 4'h4 && !bad_q && !route_q && hdr_q &&
    code_q == scp_pkg::CMD_NONE |=> route_q && !bad_q)
    else $error("Short keyword was rejected");
  srq_serial_a: assert property (port_serial && srq_req |-> !srq_out)
    else $error("Service request raised on serial port");
  buffered_a: assert property (cmd_valid |-> $past(st_q) == scp_pkg::ST_CH &&
    !$past(rx_ready))
    else $error("Command executed before message end");
endmodule

// >>> shared/scp_pkg.sv
// Notes on behaviour
// - A keyword is accepted in its full spelling or its capitalised abbreviation.
// - Any other spelling of a keyword, longer or shorter, is rejected.
// - Keywords and parameters ignore case; quoted strings keep their case.
// - An optional keyword may be left out; the command stays the same.
// - A question mark right after the keyword turns the command into a query.
// - The close query with a channel list reports state, never switches.
// - GPIB message ends on linefeed, on a byte with EOI, or both.
// - Serial message ends on CR, LF, or CR then LF, per the chosen mode.
// - Serial line-end mode powers up as LF unless a stored choice exists.
// - In LF-only serial mode each reply ends with a linefeed.
// - Common commands start with an asterisk, four or five characters long.
// - A blank separates the command keyword from its first parameter.
// - Semicolons separate commands in one message; they run in order.
// - The operation-complete query answers with the character 1.
// - The operation-complete command sets the operation-complete event flag.
// - Save stores relay states, recall restores them, from non-volatile memory.
// - Identify, reset, self-test, trigger, options and status commands are accepted.
// - Common commands behave the same on the GPIB and serial ports.
// - No service request is raised while the serial port is in use.
// - A single colon separates keywords of successive tree levels.
// - A bad command sets the command-error flag and queues an error.
package scp_pkg;
  localparam int MSG_DEPTH = 64;
  localparam int KW_CHARS  = 8;

  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_QUOTE = 8'h22;
  localparam logic [7:0] CH_STAR  = 8'h2A;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_ONE   = 8'h31;
  localparam logic [7:0] CH_NINE  = 8'h39;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_SEMI  = 8'h3B;
  localparam logic [7:0] CH_QUERY = 8'h3F;
  localparam logic [7:0] CH_LO_A  = 8'h61;
  localparam logic [7:0] CH_LO_Z  = 8'h7A;
  localparam logic [7:0] CASE_GAP = 8'h20;

  typedef enum logic [1:0] {LE_LF = 2'h0, LE_CR = 2'h1, LE_CRLF = 2'h2} scp_le_t;
  localparam scp_le_t LE_RESET = LE_LF;

  typedef enum logic [1:0] {
    ST_FILL = 2'h0,
    ST_RD   = 2'h1,
    ST_CH   = 2'h3,
    ST_RPL  = 2'h2
  } scp_state_t;

  typedef enum logic [4:0] {
    CMD_NONE  = 5'h00, CMD_CLOSE = 5'h01, CMD_OPEN = 5'h02, CMD_OPEN_ALL = 5'h03,
    CMD_IDN   = 5'h04, CMD_RST   = 5'h05, CMD_TST  = 5'h06, CMD_CLS      = 5'h07,
    CMD_ESE   = 5'h08, CMD_ESR   = 5'h09, CMD_SRE  = 5'h0A, CMD_STB      = 5'h0B,
    CMD_OPC   = 5'h0C, CMD_TRG   = 5'h0D, CMD_SAV  = 5'h0E, CMD_RCL      = 5'h0F,
    CMD_OPT   = 5'h10, CMD_ROUTE = 5'h11
  } scp_code_t;

  typedef struct packed {
    logic [7:0] data;
    logic       eoi;
  } scp_byte_t;

  typedef struct packed {
    scp_code_t  code;
    logic       query;
    logic       has_param;
    logic [7:0] param;
    logic       serial;
  } scp_cmd_t;

  function automatic logic [7:0] upcase(input logic [7:0] c);
    return (c >= CH_LO_A && c <= CH_LO_Z) ? c - CASE_GAP : c;
  endfunction

  // Short form is the long form with its lower-case tail dropped
  function automatic logic kw_is(input logic [63:0] kw, input logic [3:0] len,
                                 input logic [63:0] lng, input int ll, input int sl);
    return (len == 4'(ll) && kw == lng) ||
           (len == 4'(sl) && kw == (lng >> (8 * (ll - sl))));
  endfunction

  function automatic scp_code_t kw_lookup(input logic [63:0] kw, input logic [3:0] len);
    scp_code_t k;
    k = CMD_NONE;
    if (kw_is(kw, len, 64'("ROUTE"), 5, 4)) k = CMD_ROUTE;
    if (kw_is(kw, len, 64'("CLOSE"), 5, 4)) k = CMD_CLOSE;
    if (kw_is(kw, len, 64'("OPEN"), 4, 4)) k = CMD_OPEN;
    if (kw_is(kw, len, 64'("ALL"), 3, 3)) k = CMD_OPEN_ALL;
    if (kw_is(kw, len, 64'("*IDN"), 4, 4)) k = CMD_IDN;
    if (kw_is(kw, len, 64'("*RST"), 4, 4)) k = CMD_RST;
    if (kw_is(kw, len, 64'("*TST"), 4, 4)) k = CMD_TST;
    if (kw_is(kw, len, 64'("*CLS"), 4, 4)) k = CMD_CLS;
    if (kw_is(kw, len, 64'("*ESE"), 4, 4)) k = CMD_ESE;
    if (kw_is(kw, len, 64'("*ESR"), 4, 4)) k = CMD_ESR;
    if (kw_is(kw, len, 64'("*SRE"), 4, 4)) k = CMD_SRE;
    if (kw_is(kw, len, 64'("*STB"), 4, 4)) k = CMD_STB;
    if (kw_is(kw, len, 64'("*OPC"), 4, 4)) k = CMD_OPC;
    if (kw_is(kw, len, 64'("*TRG"), 4, 4)) k = CMD_TRG;
    if (kw_is(kw, len, 64'("*SAV"), 4, 4)) k = CMD_SAV;
    if (kw_is(kw, len, 64'("*RCL"), 4, 4)) k = CMD_RCL;
    if (kw_is(kw, len, 64'("*OPT"), 4, 4)) k = CMD_OPT;
    return k;
  endfunction

  function automatic logic query_ok(input scp_code_t c, input logic q);
    case (c)
      CMD_CLOSE, CMD_OPEN, CMD_ESE, CMD_SRE, CMD_OPC: return 1'b1;
      CMD_IDN, CMD_TST, CMD_ESR, CMD_STB, CMD_OPT:     return q;
      CMD_OPEN_ALL, CMD_RST, CMD_CLS, CMD_TRG, CMD_SAV, CMD_RCL: return !q;
      default: return 1'b0;
    endcase
  endfunction
endpackage

// >>> verilog/scp_msg_mem.sv
`timescale 1ns/1ps
module scp_msg_mem #(
  parameter int W     = 8,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata_q
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    rdata_q <= mem[raddr];
  end
endmodule

// >>> tb/scp_host.sv
`timescale 1ns/1ps
module scp_host (
  input  wire logic          mclk,
  input  wire logic [1:0]    rnd,
  input  wire logic          rx_ready,
  output logic               rx_valid,
  output scp_pkg::scp_byte_t rx,
  output logic               tx_ready
);
  initial
  begin
    rx_valid = 1'b0;
    rx       = '0;
    tx_ready = 1'b0;
  end

  // A slow host: reply bytes are taken only when the random bit allows
  always @(posedge mclk) tx_ready <= rnd[0];

  // The caller puts the configured terminator in s; EOI marks the last byte
  task automatic send(input string s, input bit eoi);
    foreach (s[i])
    begin
      if (rnd[1])
      begin
        rx_valid <= 1'b0;
        rx       <= ~rx;
        @(posedge mclk);
      end
      rx_valid <= 1'b1;
      rx       <= {8'(s[i]), eoi && i == s.len() - 1};
      @(posedge mclk iff rx_ready);
    end
    rx_valid <= 1'b0;
    rx       <= ~rx;
  endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic mclk, sys_rst, port_serial, rx_valid, rx_ready, le_wr, nv_le_valid, cmd_valid;
  logic esr_opc_set, esr_cme_set, err_push, tx_valid, tx_ready, srq_req, srq_out, ser;
  scp_pkg::scp_byte_t rx, tx;
  scp_pkg::scp_le_t   le_val, nv_le, le_mode;
  scp_pkg::scp_cmd_t  cmd;
  logic [1:0]         rnd;
  logic [31:0]        seed;
  int                 fails, samples_checked, cyc;
  logic [19:0]        eq[$];
  logic [8:0]         tq[$];
  string              msg;
  string kw[12] = '{"*IDN?", "*rst", "*Tst?", "*cls", "*ese 4", "*esr?",
                    "*sre 1", "*stb?", "*trg", "*sav 2", "*rcl 2", "*opt?"};
  logic [4:0] cc[12] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
                         5'h0A, 5'h0B, 5'h0D, 5'h0E, 5'h0F, 5'h10};

  scp_parser dut_u (.mclk, .sys_rst, .port_serial, .rx_valid, .rx, .rx_ready, .le_wr,
    .le_val, .nv_le_valid, .nv_le, .le_mode, .cmd_valid, .cmd, .esr_opc_set, .esr_cme_set,
    .err_push, .tx_valid, .tx, .tx_ready, .srq_req, .srq_out);
  scp_host host_u (.mclk, .rnd, .rx_ready, .rx_valid, .rx, .tx_ready);

  task automatic final_report;
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk_cmd(input logic [19:0] g, input logic [19:0] x);
    samples_checked++;
    if (g !== x)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic chk_val(input logic [8:0] g, input logic [8:0] x);
    samples_checked++;
    if (g !== x)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  // Expected command: flags {error, cme, opc} then the command fields
  task automatic put(input logic [4:0] c, input logic q, input int p);
    eq.push_back({2'b00, c == 5'h0C && !q, 1'b0, c, q, p != 0, 8'(p), ser});
  endtask

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic run(input string s, input bit eo);
    host_u.send(s, eo);
    for (int n = 0; n < 4000 && (eq.size() + tq.size() > 0 || rx_ready !== 1'b1); n++)
      @(negedge mclk);
    // A loop that ran out leaves work pending and counts as a mismatch
    chk_val(9'({eq.size() + tq.size() != 0, rx_ready}), 9'h001);
    @(posedge mclk);
  endtask

  task automatic rst(input logic nv);
    sys_rst     <= 1'b1;
    nv_le_valid <= nv;
    nv_le       <= scp_pkg::LE_CR;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk_val(9'(le_mode), 9'(nv ? scp_pkg::LE_CR : scp_pkg::LE_LF));
    chk_val(9'(srq_out), 9'(!port_serial));
    @(posedge mclk);
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    seed = xorshift(seed);
    rnd <= seed[1:0];
    cyc++;
    if (!sys_rst && (cmd_valid | err_push) !== 1'b0)
      chk_cmd({err_push, esr_cme_set, esr_opc_set, err_push ? 17'h0 : cmd},
              eq.size() ? eq.pop_front() : 20'hFFFFF);
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      chk_val(tx, tq.size() ? tq.pop_front() : 9'h1FF);
    if (cyc > 30000)
    begin
      chk_val(9'h001, 9'h000);
      final_report;
    end
  end

  initial
  begin
    {sys_rst, port_serial, le_wr, nv_le_valid, srq_req, ser} = 6'b100010;
    le_val = scp_pkg::LE_LF;
    nv_le = scp_pkg::LE_LF;
    seed = 32'h59;
    rnd = 2'h0;
    {fails, samples_checked, cyc} = '0;
    rst(1'b0);
    put(5'h01, 1'b0, 5);
    put(5'h01, 1'b1, 3);
    put(5'h0C, 1'b0, 0);
    run("rout:clos 5;CLOSE? 3;*opc\n", 1'b0);
    // Unknown, partial and over-long spellings must all be refused
    repeat (3) eq.push_back(20'hC0000);
    tq.push_back({8'h31, 1'b0});
    tq.push_back({8'h0A, 1'b1});
    run("DEFI;CLO 1;closex 1;*OPC?", 1'b1);
    for (int m = 0; m < 4; m++)
    begin
      ser = m[1];
      port_serial <= ser;
      msg = "";
      for (int i = 6 * (m % 2); i < 6 * (m % 2) + 6; i++)
      begin
        msg = {msg, kw[i], ";"};
        put(cc[i], kw[i][kw[i].len() - 1] == "?", kw[i].len() > 5 ? kw[i][5] - 8'h30 : 0);
      end
      run({msg, "\n"}, m % 2);
    end
    tq.push_back({8'h31, 1'b0});
    tq.push_back({8'h0A, 1'b0});
    run("*opc?\n", 1'b0);
    rst(1'b1);
    tq.push_back({8'h31, 1'b0});
    tq.push_back({8'h0D, 1'b0});
    run("*OPC?\r", 1'b0);
    le_val <= scp_pkg::LE_CRLF;
    le_wr  <= 1'b1;
    @(posedge mclk);
    le_wr <= 1'b0;
    put(5'h03, 1'b0, 0);
    run("open:all\r\n", 1'b0);
    final_report;
  end
endmodule
